// ---- core/amc_conv_ctrl.sv ----
// converter control: channel, reference, alignment, start and timing over APB
`default_nettype none
`include "amc_defs.svh"
// Notes on behaviour
// - result is 10-bit unsigned, ground to reference
// - code equals vin times 1024 over vref
// - result valid once completion flag sets
// - channel 1000 enables temperature sensor
// - mux register reference, left adjust, channel fields
// - reference codes external, supply, reserved, internal
// - selections latch only between conversions
// - channel map external, sensor, bandgap, ground
// - left adjust changes presented data immediately
// - control register field layout, reset zero
// - enable powers up, clearing aborts conversion
// - start begins one or the first conversion
// - first conversion 25 cycles, later 13
// - start reads one while converting
// - writing zero to start is ignored
// - flag sets on completion, clears by ack/one
// - prescaler divides system clock by 2..128
// - auto trigger starts on trigger rising edge
// - free running restarts while start set
module amc_conv_ctrl #(
    parameter int RES_W = 10
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [RES_W-1:0] sample_code,
    input wire logic [7:0] trigger_sources,
    input wire logic vector_ack,
    output logic converter_power,
    output logic [3:0] active_channel,
    output logic [1:0] active_reference,
    output logic temp_sensor_enable,
    output logic sample_strobe,
    output logic conversion_irq
);
    logic [7:0] mux_r;
    logic [7:0] cs_r;
    logic [2:0] trig_sel_r;
    logic [3:0] chan_act_r;
    logic [1:0] ref_act_r;
    logic [RES_W-1:0] result_r;
    logic [4:0] cyc_r;
    logic first_r;
    logic trig_prev_r;
    logic trig_pend_r;
    amc_pkg::amc_state_t state_r;
    logic cv_tick;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic wr_cs;
    logic wr_mux;
    logic wr_start;
    logic trig_level;
    logic trig_rise;
    logic begin_conv;
    logic finish;
    logic [4:0] conv_len;
    logic [15:0] presented;

    if (RES_W != 10) begin : g_bad_width
        $error("result width must be 10");
    end

    amc_prescaler #(.CNT_W(7)) u_presc (
        .clk(clk),
        .rstn(rstn),
        .run(cs_r[`AMC_CS_ENABLE]),
        .presc_sel(cs_r[`AMC_CS_PRESC_HI:0]),
        .tick(cv_tick)
    );

    // bus decode, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !pwrite;
    always_comb begin
        unique case (paddr)
            `AMC_BYTE_ADDR(`AMC_OFF_RES_LOW),
            `AMC_BYTE_ADDR(`AMC_OFF_RES_HIGH),
            `AMC_BYTE_ADDR(`AMC_OFF_CTRL_STAT),
            `AMC_BYTE_ADDR(`AMC_OFF_TRIG_SEL),
            `AMC_BYTE_ADDR(`AMC_OFF_IN_REF_SEL): hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !hit;
    assign wr_cs = wr_en && (paddr == `AMC_BYTE_ADDR(`AMC_OFF_CTRL_STAT));
    assign wr_mux = wr_en && (paddr == `AMC_BYTE_ADDR(`AMC_OFF_IN_REF_SEL));
    assign wr_start = wr_cs && pwdata[`AMC_CS_START] && pwdata[`AMC_CS_ENABLE];

    // rising edge of selected trigger; source 0 is free running
    assign trig_level = trigger_sources[trig_sel_r];
    assign trig_rise = cs_r[`AMC_CS_AUTO] && (trig_sel_r != 3'h0) && trig_level && !trig_prev_r;

    assign conv_len = first_r ? 5'(`AMC_FIRST_CYCLES) : 5'(`AMC_NORMAL_CYCLES);
    assign finish = (state_r == amc_pkg::ST_CONVERT) && cv_tick && (cyc_r == conv_len - 5'h1);
    assign begin_conv = (state_r == amc_pkg::ST_IDLE) && cv_tick
        && (cs_r[`AMC_CS_START] || trig_rise || trig_pend_r);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= trig_level;
        end
    end

    // a trigger edge outside a conversion waits for the next converter tick; edges while converting are dropped
    always_ff @(posedge clk) begin
        if (!rstn || !cs_r[`AMC_CS_ENABLE] || !cs_r[`AMC_CS_AUTO]) begin
            trig_pend_r <= 1'b0;
        end else if (begin_conv) begin
            trig_pend_r <= 1'b0;
        end else if (trig_rise && state_r != amc_pkg::ST_CONVERT) begin
            trig_pend_r <= 1'b1;
        end
    end

    // mux register, bit 4 stored as zero, reserved reference codes kept
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mux_r <= `AMC_RST_IN_REF_SEL;
        end else if (wr_mux) begin
            mux_r <= {pwdata[7:5], 1'b0, pwdata[3:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trig_sel_r <= 3'h0;
        end else if (wr_en && paddr == `AMC_BYTE_ADDR(`AMC_OFF_TRIG_SEL)) begin
            trig_sel_r <= pwdata[2:0];
        end
    end

    // selection follows the register except while converting
    always_ff @(posedge clk) begin
        if (!rstn) begin
            chan_act_r <= 4'h0;
            ref_act_r <= 2'h0;
        end else if (state_r != amc_pkg::ST_CONVERT || finish) begin
            chan_act_r <= mux_r[`AMC_MX_CHAN_HI:0];
            ref_act_r <= mux_r[`AMC_MX_REF_HI:`AMC_MX_REF_LO];
        end
    end

    // control and status register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cs_r <= `AMC_RST_CTRL_STAT;
        end else begin
            if (wr_cs) begin
                cs_r[`AMC_CS_ENABLE] <= pwdata[`AMC_CS_ENABLE];
                cs_r[`AMC_CS_AUTO] <= pwdata[`AMC_CS_AUTO];
                cs_r[`AMC_CS_IRQ_EN] <= pwdata[`AMC_CS_IRQ_EN];
                cs_r[`AMC_CS_PRESC_HI:0] <= pwdata[`AMC_CS_PRESC_HI:0];
            end
            // start: set by a one with enable, cleared on finish unless free running, or on disable
            if (wr_cs && !pwdata[`AMC_CS_ENABLE]) begin
                cs_r[`AMC_CS_START] <= 1'b0;
            end else if (wr_start) begin
                cs_r[`AMC_CS_START] <= 1'b1;
            end else if (finish && !(cs_r[`AMC_CS_AUTO] && trig_sel_r == 3'h0)) begin
                cs_r[`AMC_CS_START] <= 1'b0;
            end else if (begin_conv) begin
                cs_r[`AMC_CS_START] <= 1'b1;
            end
            // completion flag: set wins over clear
            if (finish) begin
                cs_r[`AMC_CS_DONE] <= 1'b1;
            end else if (vector_ack || (wr_cs && pwdata[`AMC_CS_DONE])) begin
                cs_r[`AMC_CS_DONE] <= 1'b0;
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= amc_pkg::ST_OFF;
            cyc_r <= 5'h0;
            first_r <= 1'b1;
        end else if (!cs_r[`AMC_CS_ENABLE]) begin
            state_r <= amc_pkg::ST_OFF;
            cyc_r <= 5'h0;
            first_r <= 1'b1;
        end else begin
            unique case (state_r)
                amc_pkg::ST_OFF: begin
                    state_r <= amc_pkg::ST_IDLE;
                end
                amc_pkg::ST_IDLE: begin
                    if (begin_conv) begin
                        state_r <= amc_pkg::ST_CONVERT;
                        cyc_r <= 5'h0;
                    end
                end
                amc_pkg::ST_CONVERT: begin
                    if (finish) begin
                        state_r <= amc_pkg::ST_IDLE;
                        first_r <= 1'b0;
                    end else if (cv_tick) begin
                        cyc_r <= cyc_r + 5'h1;
                    end
                end
            endcase
        end
    end

    // result capture at completion
    always_ff @(posedge clk) begin
        if (!rstn) begin
            result_r <= '0;
        end else if (finish) begin
            result_r <= sample_code;
        end
    end

    // alignment applied at read time
    assign presented = mux_r[`AMC_MX_LEFT] ? {result_r, 6'h00} : {6'h00, result_r};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            unique case (paddr)
                `AMC_BYTE_ADDR(`AMC_OFF_RES_LOW): prdata <= {24'h000000, presented[7:0]};
                `AMC_BYTE_ADDR(`AMC_OFF_RES_HIGH): prdata <= {24'h000000, presented[15:8]};
                `AMC_BYTE_ADDR(`AMC_OFF_CTRL_STAT): prdata <= {24'h000000, cs_r};
                `AMC_BYTE_ADDR(`AMC_OFF_TRIG_SEL): prdata <= {29'h0000000, trig_sel_r};
                `AMC_BYTE_ADDR(`AMC_OFF_IN_REF_SEL): prdata <= {24'h000000, mux_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign converter_power = cs_r[`AMC_CS_ENABLE];
    assign active_channel = chan_act_r;
    assign active_reference = ref_act_r;
    assign temp_sensor_enable = (chan_act_r == 4'h8);
    assign sample_strobe = finish;
    assign conversion_irq = cs_r[`AMC_CS_DONE] && cs_r[`AMC_CS_IRQ_EN];

    a_start_clears: assert property (@(posedge clk) disable iff (!rstn)
        (finish && !cs_r[`AMC_CS_AUTO] && !wr_cs) |=> !cs_r[`AMC_CS_START])
        else $error("start bit not cleared at completion");
    a_flag_sets: assert property (@(posedge clk) disable iff (!rstn)
        finish |=> cs_r[`AMC_CS_DONE] && result_r == $past(sample_code))
        else $error("completion flag or result not updated");
    a_sel_locked: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == amc_pkg::ST_CONVERT && !finish && cs_r[`AMC_CS_ENABLE]) |=> $stable(chan_act_r))
        else $error("channel changed mid conversion");
    a_disable_aborts: assert property (@(posedge clk) disable iff (!rstn)
        (wr_cs && !pwdata[`AMC_CS_ENABLE]) |=> ##1 state_r == amc_pkg::ST_OFF && !cs_r[`AMC_CS_START])
        else $error("disable did not abort");
    a_zero_start: assert property (@(posedge clk) disable iff (!rstn)
        (wr_cs && pwdata[`AMC_CS_ENABLE] && !pwdata[`AMC_CS_START] && cs_r[`AMC_CS_START] && !finish)
        |=> cs_r[`AMC_CS_START])
        else $error("zero write altered start");
    a_len_normal: assert property (@(posedge clk) disable iff (!rstn)
        finish |-> cyc_r == (first_r ? 5'd24 : 5'd12))
        else $error("wrong conversion length");
    a_left_adj: assert property (@(posedge clk) disable iff (!rstn)
        mux_r[`AMC_MX_LEFT] |-> presented[5:0] == 6'h00 && presented[15:6] == result_r)
        else $error("left adjust wrong");
    a_temp_sense: assert property (@(posedge clk) disable iff (!rstn)
        (state_r != amc_pkg::ST_CONVERT && mux_r[`AMC_MX_CHAN_HI:0] == 4'h8) |=> temp_sensor_enable)
        else $error("temperature sensor not enabled");
    a_mux_reset: assert property (@(posedge clk)
        !rstn |=> mux_r == 8'h00 && cs_r == 8'h00)
        else $error("registers not reset");
    a_trig_start: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == amc_pkg::ST_IDLE && cv_tick && trig_pend_r) |=> state_r == amc_pkg::ST_CONVERT)
        else $error("pending trigger did not start");
    a_trig_clear: assert property (@(posedge clk) disable iff (!rstn)
        !cs_r[`AMC_CS_AUTO] |=> !trig_pend_r)
        else $error("trigger pending without auto trigger");
    a_busy_start: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == amc_pkg::ST_CONVERT && cs_r[`AMC_CS_ENABLE]) |-> cs_r[`AMC_CS_START])
        else $error("start bit low while converting");
    a_begin_idle: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == amc_pkg::ST_IDLE && cv_tick && cs_r[`AMC_CS_START]) |=> state_r == amc_pkg::ST_CONVERT)
        else $error("start did not begin a conversion");
    a_free_restart: assert property (@(posedge clk) disable iff (!rstn)
        (finish && cs_r[`AMC_CS_AUTO] && trig_sel_r == 3'h0 && !wr_cs) |=> cs_r[`AMC_CS_START])
        else $error("free running start bit dropped");
    a_off_state: assert property (@(posedge clk) disable iff (!rstn)
        !cs_r[`AMC_CS_ENABLE] |=> state_r == amc_pkg::ST_OFF)
        else $error("sequencer running while disabled");
    a_off_quiet: assert property (@(posedge clk) disable iff (!rstn)
        !cs_r[`AMC_CS_ENABLE] |-> !sample_strobe)
        else $error("completion while disabled");
    a_first_after_off: assert property (@(posedge clk) disable iff (!rstn)
        state_r == amc_pkg::ST_OFF |-> first_r)
        else $error("long first conversion not armed");
    a_done_ack: assert property (@(posedge clk) disable iff (!rstn)
        (vector_ack && !finish) |=> !cs_r[`AMC_CS_DONE])
        else $error("vector ack did not clear flag");
    a_done_sw: assert property (@(posedge clk) disable iff (!rstn)
        (wr_cs && pwdata[`AMC_CS_DONE] && !finish) |=> !cs_r[`AMC_CS_DONE])
        else $error("writing one did not clear flag");
    a_strobe_pulse: assert property (@(posedge clk) disable iff (!rstn)
        sample_strobe |=> !sample_strobe)
        else $error("completion strobe longer than one cycle");
    a_result_hold: assert property (@(posedge clk) disable iff (!rstn)
        !finish |=> $stable(result_r))
        else $error("result changed without completion");
    a_sel_follow: assert property (@(posedge clk) disable iff (!rstn)
        (state_r != amc_pkg::ST_CONVERT) |=> chan_act_r == $past(mux_r[`AMC_MX_CHAN_HI:0])
        && ref_act_r == $past(mux_r[`AMC_MX_REF_HI:`AMC_MX_REF_LO]))
        else $error("selection not following register");
    a_mux_write: assert property (@(posedge clk) disable iff (!rstn)
        wr_mux |=> mux_r == {$past(pwdata[7:5]), 1'b0, $past(pwdata[3:0])})
        else $error("mux register write wrong");
    // read path
    a_read_high: assert property (@(posedge clk) disable iff (!rstn)
        (rd_en && !penable && !finish && paddr == `AMC_BYTE_ADDR(`AMC_OFF_RES_HIGH))
        |=> prdata[7:0] == (mux_r[`AMC_MX_LEFT] ? result_r[9:2] : {6'h00, result_r[9:8]}))
        else $error("result high byte wrong");
    a_read_low: assert property (@(posedge clk) disable iff (!rstn)
        (rd_en && !penable && !finish && paddr == `AMC_BYTE_ADDR(`AMC_OFF_RES_LOW))
        |=> prdata[7:0] == (mux_r[`AMC_MX_LEFT] ? {result_r[1:0], 6'h00} : result_r[7:0]))
        else $error("result low byte wrong");
    a_read_mux: assert property (@(posedge clk) disable iff (!rstn)
        (rd_en && !penable && paddr == `AMC_BYTE_ADDR(`AMC_OFF_IN_REF_SEL)) |=> prdata == {24'h000000, $past(mux_r)})
        else $error("mux register read wrong");
    a_read_status: assert property (@(posedge clk) disable iff (!rstn)
        (rd_en && !penable && paddr == `AMC_BYTE_ADDR(`AMC_OFF_CTRL_STAT)) |=> prdata == {24'h000000, $past(cs_r)})
        else $error("status register read wrong");
    a_read_unmapped: assert property (@(posedge clk) disable iff (!rstn)
        (rd_en && !penable && !hit) |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : amc_conv_ctrl
`default_nettype wire

// ---- core/amc_defs.svh ----
// offsets, field positions, reset values and timing counts of the converter control block
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH
`define AMC_OFF_RES_LOW 8'h78
`define AMC_OFF_RES_HIGH 8'h79
`define AMC_OFF_CTRL_STAT 8'h7A
`define AMC_OFF_TRIG_SEL 8'h7B
`define AMC_OFF_IN_REF_SEL 8'h7C
`define AMC_BYTE_ADDR(idx) ({22'h0, (idx), 2'b00})
`define AMC_CS_ENABLE 7
`define AMC_CS_START 6
`define AMC_CS_AUTO 5
`define AMC_CS_DONE 4
`define AMC_CS_IRQ_EN 3
`define AMC_CS_PRESC_HI 2
`define AMC_MX_REF_HI 7
`define AMC_MX_REF_LO 6
`define AMC_MX_LEFT 5
`define AMC_MX_CHAN_HI 3
`define AMC_RST_CTRL_STAT 8'h00
`define AMC_RST_IN_REF_SEL 8'h00
`define AMC_FIRST_CYCLES 25
`define AMC_NORMAL_CYCLES 13
`define AMC_FULL_SCALE 1024
`endif

// ---- core/amc_pkg.sv ----
// types shared by the converter control block
`default_nettype none
package amc_pkg;
    typedef enum logic [1:0] {
        REF_EXT_PIN,
        REF_SUPPLY,
        REF_RESERVED,
        REF_INTERNAL
    } amc_ref_t;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_IDLE,
        ST_CONVERT
    } amc_state_t;
endpackage : amc_pkg
`default_nettype wire

// ---- core/amc_prescaler.sv ----
// converter clock tick generator from the system clock
`default_nettype none
module amc_prescaler #(
    parameter int CNT_W = 7
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [2:0] presc_sel,
    output logic tick
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask;

    if (CNT_W < 7) begin : g_bad_width
        $error("prescaler counter too narrow");
    end

    // codes 0 and 1 both divide by two
    always_comb begin
        mask = (presc_sel == 3'h0) ? {{(CNT_W-1){1'b0}}, 1'b1} : CNT_W'((1 << presc_sel) - 1);
    end

    always_ff @(posedge clk) begin
        if (!rstn || !run) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick = run && ((cnt_r & mask) == mask);

    a_tick_gap: assert property (@(posedge clk) disable iff (!rstn)
        tick |=> !tick)
        else $error("converter tick faster than divide by two");
endmodule : amc_prescaler
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the converter control block
`default_nettype none
`include "amc_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_LO = `AMC_BYTE_ADDR(`AMC_OFF_RES_LOW);
    localparam logic [31:0] A_HI = `AMC_BYTE_ADDR(`AMC_OFF_RES_HIGH);
    localparam logic [31:0] A_CS = `AMC_BYTE_ADDR(`AMC_OFF_CTRL_STAT);
    localparam logic [31:0] A_TS = `AMC_BYTE_ADDR(`AMC_OFF_TRIG_SEL);
    localparam logic [31:0] A_MX = `AMC_BYTE_ADDR(`AMC_OFF_IN_REF_SEL);
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] sample_code = 10'h2A7;
    logic [7:0] trigger_sources = 8'h00;
    logic vector_ack = 1'b0;
    logic converter_power;
    logic [3:0] active_channel;
    logic [1:0] active_reference;
    logic temp_sensor_enable;
    logic sample_strobe;
    logic conversion_irq;
    int error_cnt = 0;
    int check_count = 0;
    int ts;
    int n1;
    int n2;
    logic [31:0] rd;
    logic er;
    amc_conv_ctrl dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_code(sample_code), .trigger_sources(trigger_sources), .vector_ack(vector_ack),
        .converter_power(converter_power), .active_channel(active_channel),
        .active_reference(active_reference), .temp_sensor_enable(temp_sensor_enable),
        .sample_strobe(sample_strobe), .conversion_irq(conversion_irq));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // register read with expected low byte
    task automatic rchk(input logic [31:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk({24'h0, rd[7:0]}, {24'h0, exp});
    endtask : rchk
    // counts cycles until the completion pulse, 0 if none
    task automatic wait_strobe(input int lim);
        int k;
        k = 0;
        ts = 0;
        while (ts == 0 && k < lim) begin
            @(negedge clk);
            k++;
            if (sample_strobe === 1'b1) ts = k;
        end
    endtask : wait_strobe
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    initial begin
        #500000;
        error_cnt++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rchk(A_CS, 8'h00);
        rchk(A_MX, 8'h00);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, A_MX, {24'h0, i[1:0], 2'b00, i[3:0]});
            rchk(A_MX, {i[1:0], 2'b00, i[3:0]});
        end
        apb(1'b1, A_MX, 32'hFF);
        rchk(A_MX, 8'hEF);
        apb(1'b1, A_MX, 32'h00);
        apb(1'b0, 32'h1FC, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        chk({31'h0, pready}, 32'h1);
        apb(1'b1, A_CS, 32'h40);
        rchk(A_CS, 8'h00);
        apb(1'b1, A_CS, 32'hC0);
        rchk(A_CS, 8'hC0);
        wait_strobe(300);
        n1 = ts + 2;
        rchk(A_CS, 8'h90);
        rchk(A_LO, 8'hA7);
        rchk(A_HI, 8'h02);
        apb(1'b1, A_CS, 32'h90);
        rchk(A_CS, 8'h80);
        apb(1'b1, A_CS, 32'hC8);
        wait_strobe(300);
        n2 = ts;
        chk({31'h0, n2 > 0 && n1 - n2 >= 23 && n1 - n2 <= 25}, 32'h1);
        @(negedge clk);
        chk({31'h0, conversion_irq}, 32'h1);
        @(posedge clk);
        vector_ack <= 1'b1;
        @(posedge clk);
        vector_ack <= 1'b0;
        @(negedge clk);
        chk({31'h0, conversion_irq}, 32'h0);
        apb(1'b1, A_CS, 32'hC0);
        sample_code <= 10'h3FF;
        apb(1'b1, A_MX, 32'hC8);
        apb(1'b1, A_CS, 32'h80);
        @(negedge clk);
        chk({28'h0, active_channel, active_reference}, 32'h0);
        rchk(A_CS, 8'hC0);
        wait_strobe(300);
        @(negedge clk);
        chk({27'h0, active_channel, temp_sensor_enable}, 32'h11);
        chk({30'h0, active_reference}, 32'h3);
        rchk(A_HI, 8'h03);
        apb(1'b1, A_MX, 32'hE8);
        rchk(A_HI, 8'hFF);
        rchk(A_LO, 8'hC0);
        apb(1'b1, A_CS, 32'hD3);
        wait_strobe(300);
        chk({31'h0, ts >= 104 && ts <= 124}, 32'h1);
        apb(1'b1, A_CS, 32'hC0);
        repeat (10) @(posedge clk);
        apb(1'b1, A_CS, 32'h00);
        wait_strobe(150);
        chk(ts, 32'h0);
        chk({31'h0, converter_power}, 32'h0);
        apb(1'b1, A_CS, 32'hE0);
        wait_strobe(300);
        wait_strobe(300);
        chk({31'h0, ts > 0}, 32'h1);
        rchk(A_CS, 8'hF0);
        apb(1'b1, A_CS, 32'h00);
        apb(1'b1, A_TS, 32'h01);
        apb(1'b1, A_CS, 32'hB0);
        wait_strobe(100);
        chk(ts, 32'h0);
        @(posedge clk);
        trigger_sources <= 8'h02;
        wait_strobe(300);
        chk({31'h0, ts > 0}, 32'h1);
        apb(1'b1, A_CS, 32'h00);
        results();
    end
endmodule : tb_top
`default_nettype wire
